// ===== bench/hbcs_checker.sv
// concurrent checks on the shared host bus pins
`timescale 1ns/100ps
module hbcs_checker (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       bus_sync,
  input wire logic [1:0] transfer_size,
  input wire logic       dev_size_oe_n,
  input wire logic       host_size_oe_n,
  input wire logic       sync_cycle_ack_n,
  input wire logic       bus_fault_n,
  input wire logic       dev_ack_oe_n,
  input wire logic       dev_fault_oe_n,
  input wire logic       transfer_in_progress_n,
  input wire logic       master_strobe_n,
  input wire logic       slave_strobe_n,
  input wire logic       slave_cycle_done_n,
  input wire logic [2:0] space_qualifier,
  input wire logic       space_qualifier_oe_n,
  input wire logic [1:0] snoop_level,
  input wire logic       master_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_async_no_line;
    !bus_sync && !dev_size_oe_n |-> transfer_size != 2'h3;
  endproperty
  a_async_no_line: assert property (p_async_no_line) else $error("line size in async");
  property p_size_owner;
    !dev_size_oe_n |-> !master_n && host_size_oe_n;
  endproperty
  a_size_owner: assert property (p_size_owner) else $error("size driven by non master");
  property p_strobe_start;
    $fell(master_n) |-> !master_strobe_n ##1 master_strobe_n;
  endproperty
  a_strobe_start: assert property (p_strobe_start) else $error("master start without strobe");
  property p_hold;
    !master_n && !$fell(master_n) && $past(sync_cycle_ack_n) && $past(bus_fault_n)
      |-> $stable(transfer_size) && $stable(space_qualifier) && $stable(snoop_level);
  endproperty
  a_hold: assert property (p_hold) else $error("qualifiers moved in cycle");
  property p_done_holds;
    !slave_cycle_done_n && sync_cycle_ack_n && bus_fault_n |=> !slave_cycle_done_n;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("slave done left early");
  property p_done_ends;
    $fell(slave_cycle_done_n) |-> ##[1:2] slave_cycle_done_n;
  endproperty
  a_done_ends: assert property (p_done_ends) else $error("slave done stuck");
  property p_slave_done;
    $fell(slave_strobe_n) |-> ##[3:6] (!slave_cycle_done_n || !bus_fault_n);
  endproperty
  a_slave_done: assert property (p_slave_done) else $error("no slave completion");
  property p_tip_sync;
    bus_sync && !master_n |-> !transfer_in_progress_n;
  endproperty
  a_tip_sync: assert property (p_tip_sync) else $error("tip high while master");
  property p_dev_dir;
    !dev_ack_oe_n || !dev_fault_oe_n |-> master_n;
  endproperty
  a_dev_dir: assert property (p_dev_dir) else $error("ack or fault driven as master");
  property p_release;
    !master_n && !$fell(master_n) && !sync_cycle_ack_n |=> master_n && dev_size_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("ack did not end master cycle");
  property p_sq_master;
    !master_n |-> !space_qualifier_oe_n && !dev_size_oe_n;
  endproperty
  a_sq_master: assert property (p_sq_master) else $error("qualifiers not driven");
endmodule

// ===== bench/host_bus_cycle_signalling_test.sv
// self-checking bench for the device and host ends facing each other
`timescale 1ns/100ps
module host_bus_cycle_signalling_test;
  logic       clock    = 1'b0;
  logic       nrst     = 1'b0;
  logic       aen      = 1'b1;
  logic       pss      = 1'b1;
  logic [1:0] dms      = 2'h2;
  logic [1:0] scc      = 2'h1;
  logic       spo      = 1'b0;
  logic       nif      = 1'b0;
  logic       m_req    = 1'b0;
  logic [1:0] m_size   = 2'h0;
  logic       m_prog   = 1'b0;
  logic       sel      = 1'b0;
  logic [1:0] mem_resp = 2'h0;
  logic       cpu_req  = 1'b0;
  logic [1:0] cpu_size = 2'h0;
  logic       m_busy, m_done, m_fault, s_start, s_end, mem_cyc, cpu_done, cpu_fault, cpu_refused;
  logic [1:0] s_size, mem_size, mem_snoop;
  logic [2:0] mem_space;
  int         num_errors  = 0;
  int         check_count = 0;
  always #4 clock = ~clock;
  hbcs_if u_hbcs_if ();
  hbcs_dev u_hbcs_dev (.clock(clock), .nrst(nrst), .bus(u_hbcs_if), .ack_bidir_enable(aen),
    .program_space_select(pss), .dma_mode_space(dms), .snoop_level_cfg(scc), .snoop_pure_out(spo),
    .next_is_fetch(nif), .m_req(m_req), .m_size(m_size), .m_prog(m_prog), .m_busy(m_busy),
    .m_done(m_done), .m_fault(m_fault), .s_start(s_start), .s_size(s_size), .s_end(s_end));
  hbcs_host u_hbcs_host (.clock(clock), .nrst(nrst), .bus(u_hbcs_if), .bus_sync_sel(sel),
    .mem_resp(mem_resp), .cpu_req(cpu_req), .cpu_size(cpu_size), .mem_cyc(mem_cyc), .mem_size(mem_size),
    .mem_space(mem_space), .mem_snoop(mem_snoop), .cpu_done(cpu_done), .cpu_fault(cpu_fault),
    .cpu_refused(cpu_refused));
  hbcs_checker u_hbcs_checker (.clock(clock), .nrst(nrst), .bus_sync(u_hbcs_if.bus_sync),
    .transfer_size(u_hbcs_if.transfer_size), .dev_size_oe_n(u_hbcs_if.dev_size_oe_n),
    .host_size_oe_n(u_hbcs_if.host_size_oe_n), .sync_cycle_ack_n(u_hbcs_if.sync_cycle_ack_n),
    .bus_fault_n(u_hbcs_if.bus_fault_n), .dev_ack_oe_n(u_hbcs_if.dev_ack_oe_n),
    .dev_fault_oe_n(u_hbcs_if.dev_fault_oe_n), .transfer_in_progress_n(u_hbcs_if.transfer_in_progress_n),
    .master_strobe_n(u_hbcs_if.master_strobe_n), .slave_strobe_n(u_hbcs_if.slave_strobe_n),
    .slave_cycle_done_n(u_hbcs_if.slave_cycle_done_n), .space_qualifier(u_hbcs_if.space_qualifier),
    .space_qualifier_oe_n(u_hbcs_if.space_qualifier_oe_n), .snoop_level(u_hbcs_if.snoop_level),
    .master_n(u_hbcs_if.master_n));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // master cycle: size, prog, response, expected size, fault and bus cycle count
  task automatic mst(input logic [1:0] sz, input logic pg, input logic [1:0] rs, input logic [1:0] xs,
                     input logic xf, input int xc);
    int   n;
    int   c;
    logic dn;
    logic fl;
    n = 0;
    c = 0;
    dn = 1'b0;
    fl = 1'b0;
    mem_resp <= rs;
    m_size   <= sz;
    m_prog   <= pg;
    m_req    <= 1'b1;
    @(posedge clock);
    m_req <= 1'b0;
    while (!dn && n < 40) begin
      @(negedge clock);
      n++;
      dn = (m_done === 1'b1);
      if (mem_cyc === 1'b1) begin
        c++;
        chk({1'b0, mem_size, mem_space, mem_snoop}, {1'b0, xs, dms, ~(pss & pg), scc}, "qualifiers");
        chk({5'h0, u_hbcs_if.master_n, m_busy, u_hbcs_if.snoop_level_oe_n}, 8'h2, "master status");
      end
      if (u_hbcs_if.bus_fault_n === 1'b0) fl = 1'b1;
      if (!dn) begin
        @(posedge clock);
        if (fl) mem_resp <= 2'h0;
      end
    end
    chk({6'h0, m_done, m_fault}, {6'h0, 1'b1, xf}, "master end");
    chk(8'(c), 8'(xc), "bus cycles");
    @(posedge clock);
  endtask
  // slave access: size, expected {done, fault, refused}
  task automatic slv(input logic [1:0] sz, input logic [2:0] xe);
    int   n;
    logic st;
    logic dn;
    n = 0;
    st = 1'b0;
    dn = 1'b0;
    cpu_size <= sz;
    cpu_req  <= 1'b1;
    @(posedge clock);
    cpu_req <= 1'b0;
    while (!dn && n < 40) begin
      @(negedge clock);
      n++;
      dn = (cpu_done === 1'b1 || cpu_refused === 1'b1);
      if (s_start === 1'b1) st = 1'b1;
    end
    chk({3'h0, st, s_end, cpu_done, cpu_fault, cpu_refused}, {3'h0, xe[2], xe[2], xe}, "slave end");
    if (xe[2]) chk({6'h0, s_size}, {6'h0, sz}, "slave size");
    @(posedge clock);
  endtask
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    chk({5'h0, u_hbcs_if.bus_sync, u_hbcs_if.master_n, u_hbcs_if.fetch_n}, 8'h3, "idle async");
    chk({7'h0, u_hbcs_if.snoop_level_oe_n}, 8'h1, "snoop idle");
    for (int i = 0; i < 4; i++) begin
      mst(2'(i), i[0], 2'h0, (i == 3) ? 2'h0 : 2'(i), 1'b0, 1);
    end
    pss <= 1'b0;
    mst(2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 1);
    mst(2'h1, 1'b0, 2'h1, 2'h1, 1'b1, 1);
    mst(2'h2, 1'b0, 2'h2, 2'h2, 1'b0, 2);
    $display("test async master done at %0t", $time);
    for (int i = 0; i < 3; i++) begin
      slv(2'(i), 3'h4);
    end
    aen <= 1'b0;
    slv(2'h1, 3'h4);
    slv(2'h3, 3'h1);
    $display("test async slave done at %0t", $time);
    sel <= 1'b1;
    nif <= 1'b1;
    spo <= 1'b1;
    repeat (3) @(posedge clock);
    chk({5'h0, u_hbcs_if.bus_sync, u_hbcs_if.fetch_n, u_hbcs_if.snoop_level_oe_n}, 8'h4, "sync idle");
    chk({6'h0, u_hbcs_if.snoop_level}, {6'h0, scc}, "pure snoop");
    mst(2'h3, 1'b1, 2'h0, 2'h3, 1'b0, 1);
    mst(2'h0, 1'b0, 2'h2, 2'h0, 1'b1, 1);
    slv(2'h3, 3'h4);
    $display("test sync done at %0t", $time);
    end_of_test();
  end
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end
endmodule

// ===== rtl/hbcs_cfg.svh
// constants for the host bus cycle signalling ends
`ifndef HBCS_CFG_SVH
`define HBCS_CFG_SVH
`define HBCS_SIZ_LONG 2'h0
`define HBCS_SIZ_BYTE 2'h1
`define HBCS_SIZ_WORD 2'h2
`define HBCS_SIZ_LINE 2'h3
`define HBCS_FC0_DATA 1'h1
`define HBCS_FC0_PROG 1'h0
`define HBCS_SLV_LAT  4'h2
`define HBCS_MEM_LAT  4'h1
`define HBCS_RSP_ACK  2'h0
`define HBCS_RSP_FLT  2'h1
`define HBCS_RSP_RTY  2'h2
`endif

// ===== rtl/hbcs_dev.sv
// device end of the host bus cycle signalling
// Overview of operation
// - size 00 long, 01 byte, 10 word
// - size 11 only as sync burst
// - memory acks master cycles via ack pin
// - ack enable makes ack pin bidirectional
// - bus fault: device in slave, host in master
// - async retry: transfer in progress low together with bus fault
// - sync: bus owner drives transfer in progress
// - slave done marks internal slave completion
// - slave cycle ends on ack or fault
// - space bit 0 high for data
// - program select drives space bit 0 low on prog accesses
// - space bits 2:1 from dma mode bits
// - snoop level driven while master, and always with pure output
// - pure output option drives snoop always
// - master status low while bus master
// - fetch output flags next request opcode
// - size driven by current master only
// - bus select pin picks sync or async
`timescale 1ns/100ps
`include "hbcs_cfg.svh"
module hbcs_dev
  import hbcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  hbcs_if.dev             bus,
  input  wire logic       ack_bidir_enable,
  input  wire logic       program_space_select,
  input  wire logic [1:0] dma_mode_space,
  input  wire logic [1:0] snoop_level_cfg,
  input  wire logic       snoop_pure_out,
  input  wire logic       next_is_fetch,
  input  wire logic       m_req,
  input  wire logic [1:0] m_size,
  input  wire logic       m_prog,
  output logic            m_busy,
  output logic            m_done,
  output logic            m_fault,
  output logic            s_start,
  output logic [1:0]      s_size,
  output logic            s_end
);
  hbcs_dev_s state_ff;
  hbcs_dev_s nxt_state;
  logic      mst_run;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.mstb_n = 1'h1;
    nxt_state.m_done = 1'h0;
    nxt_state.m_fault = 1'h0;
    nxt_state.s_start = 1'h0;
    nxt_state.s_end = 1'h0;
    nxt_state.fetch_n = ~next_is_fetch;
    case (state_ff.st)
      ds_idle: begin
        if (!bus.slave_strobe_n) begin
          nxt_state.st = ds_slv;
          nxt_state.s_siz = bus.transfer_size;
          nxt_state.cnt = `HBCS_SLV_LAT;
          nxt_state.s_start = 1'h1;
          if (bus.bus_sync) begin
            nxt_state.tip_oe_n = 1'h1;
          end
        end else if (m_req) begin
          nxt_state.st = ds_mst;
          if (m_size == `HBCS_SIZ_LINE && !bus.bus_sync) begin
            nxt_state.siz = `HBCS_SIZ_LONG;
          end else begin
            nxt_state.siz = m_size;
          end
          nxt_state.siz_oe_n = 1'h0;
          nxt_state.sq[2:1] = dma_mode_space;
          if (program_space_select && m_prog) begin
            nxt_state.sq[0] = `HBCS_FC0_PROG;
          end else begin
            nxt_state.sq[0] = `HBCS_FC0_DATA;
          end
          nxt_state.sq_oe_n = 1'h0;
          nxt_state.sc = snoop_level_cfg;
          nxt_state.mst_n = 1'h0;
          nxt_state.mst_oe_n = 1'h0;
          nxt_state.mstb_n = 1'h0;
          nxt_state.ack_oe_n = 1'h1;
          nxt_state.flt_oe_n = 1'h1;
          nxt_state.tip_n = 1'h0;
          nxt_state.tip_oe_n = ~bus.bus_sync;
        end
      end
      ds_mst: begin
        if (!bus.bus_fault_n) begin
          if (!bus.bus_sync && !bus.transfer_in_progress_n) begin
            nxt_state.mstb_n = 1'h0;
          end else begin
            nxt_state.st = ds_idle;
            nxt_state.m_done = 1'h1;
            nxt_state.m_fault = 1'h1;
          end
        end else if (!bus.sync_cycle_ack_n) begin
          nxt_state.st = ds_idle;
          nxt_state.m_done = 1'h1;
        end
        if (nxt_state.st == ds_idle) begin
          nxt_state.siz_oe_n = 1'h1;
          nxt_state.sq_oe_n = 1'h1;
          nxt_state.mst_n = 1'h1;
          nxt_state.mst_oe_n = 1'h1;
          nxt_state.tip_n = 1'h1;
          nxt_state.tip_oe_n = 1'h1;
        end
      end
      ds_slv: begin
        if (!bus.bus_sync && state_ff.s_siz == `HBCS_SIZ_LINE) begin
          nxt_state.flt_n = 1'h0;
          nxt_state.flt_oe_n = 1'h0;
          nxt_state.st = ds_wait;
        end else if (state_ff.cnt == 4'h0) begin
          nxt_state.done_n = 1'h0;
          nxt_state.st = ds_wait;
          if (ack_bidir_enable) begin
            nxt_state.ack_n = 1'h0;
            nxt_state.ack_oe_n = 1'h0;
          end
        end else begin
          nxt_state.cnt = state_ff.cnt - 4'h1;
        end
      end
      ds_wait: begin
        if (!bus.sync_cycle_ack_n || !bus.bus_fault_n) begin
          nxt_state.st = ds_idle;
          nxt_state.s_end = 1'h1;
          nxt_state.done_n = 1'h1;
          nxt_state.ack_n = 1'h1;
          nxt_state.ack_oe_n = 1'h1;
          nxt_state.flt_n = 1'h1;
          nxt_state.flt_oe_n = 1'h1;
        end
      end
      default: begin
        nxt_state.st = ds_idle;
      end
    endcase
    mst_run = (nxt_state.st == ds_mst);
    if (!mst_run) begin
      nxt_state.sc = snoop_level_cfg;
    end
    nxt_state.sc_oe_n = ~(mst_run | snoop_pure_out);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{
        st:       ds_idle,
        cnt:      4'h0,
        siz:      `HBCS_SIZ_LONG,
        sq:       {2'h0, `HBCS_FC0_DATA},
        sc:       2'h0,
        s_siz:    2'h0,
        siz_oe_n: 1'h1,
        sq_oe_n:  1'h1,
        sc_oe_n:  1'h1,
        mst_n:    1'h1,
        mst_oe_n: 1'h1,
        mstb_n:   1'h1,
        tip_n:    1'h1,
        tip_oe_n: 1'h1,
        ack_n:    1'h1,
        ack_oe_n: 1'h1,
        flt_n:    1'h1,
        flt_oe_n: 1'h1,
        done_n:   1'h1,
        fetch_n:  1'h1,
        m_done:   1'h0,
        m_fault:  1'h0,
        s_start:  1'h0,
        s_end:    1'h0
      };
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bus.dev_size_o = state_ff.siz;
  assign bus.dev_size_oe_n = state_ff.siz_oe_n;
  assign bus.dev_ack_o = state_ff.ack_n;
  assign bus.dev_ack_oe_n = state_ff.ack_oe_n;
  assign bus.dev_fault_o = state_ff.flt_n;
  assign bus.dev_fault_oe_n = state_ff.flt_oe_n;
  assign bus.dev_tip_o = state_ff.tip_n;
  assign bus.dev_tip_oe_n = state_ff.tip_oe_n;
  assign bus.master_strobe_n = state_ff.mstb_n;
  assign bus.slave_cycle_done_n = state_ff.done_n;
  assign bus.space_qualifier = state_ff.sq;
  assign bus.space_qualifier_oe_n = state_ff.sq_oe_n;
  assign bus.snoop_level = state_ff.sc;
  assign bus.snoop_level_oe_n = state_ff.sc_oe_n;
  assign bus.master_n = state_ff.mst_n;
  assign bus.master_oe_n = state_ff.mst_oe_n;
  assign bus.fetch_n = state_ff.fetch_n;
  assign m_busy = ~state_ff.mst_n;
  assign m_done = state_ff.m_done;
  assign m_fault = state_ff.m_fault;
  assign s_start = state_ff.s_start;
  assign s_size = state_ff.s_siz;
  assign s_end = state_ff.s_end;
endmodule

// ===== rtl/hbcs_host.sv
// host end: bus select, memory responder and cpu slave access
`timescale 1ns/100ps
`include "hbcs_cfg.svh"
module hbcs_host
  import hbcs_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  hbcs_if.host            bus,
  input  wire logic       bus_sync_sel,
  input  wire logic [1:0] mem_resp,
  input  wire logic       cpu_req,
  input  wire logic [1:0] cpu_size,
  output logic            mem_cyc,
  output logic [1:0]      mem_size,
  output logic [2:0]      mem_space,
  output logic [1:0]      mem_snoop,
  output logic            cpu_done,
  output logic            cpu_fault,
  output logic            cpu_refused
);
  hbcs_host_s state_ff;
  hbcs_host_s nxt_state;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.sync = bus_sync_sel;
    nxt_state.sstb_n = 1'h1;
    nxt_state.mem_cyc = 1'h0;
    nxt_state.cpu_done = 1'h0;
    nxt_state.cpu_fault = 1'h0;
    nxt_state.cpu_refused = 1'h0;
    case (state_ff.st)
      hs_idle: begin
        if (!bus.master_strobe_n) begin
          nxt_state.st = hs_mem;
          nxt_state.cnt = `HBCS_MEM_LAT;
          nxt_state.mem_cyc = 1'h1;
          nxt_state.mem_size = bus.transfer_size;
          nxt_state.mem_space = bus.space_qualifier;
          nxt_state.mem_snoop = bus.snoop_level;
        end else if (cpu_req && bus.master_n) begin
          if (!state_ff.sync && cpu_size == `HBCS_SIZ_LINE) begin
            nxt_state.cpu_refused = 1'h1;
          end else begin
            nxt_state.st = hs_slv;
            nxt_state.siz_o = cpu_size;
            nxt_state.siz_oe_n = 1'h0;
            nxt_state.sstb_n = 1'h0;
            nxt_state.tip_n = 1'h0;
            nxt_state.tip_oe_n = ~state_ff.sync;
          end
        end
      end
      hs_mem: begin
        if (state_ff.cnt == 4'h0) begin
          nxt_state.st = hs_rsp;
          if (mem_resp == `HBCS_RSP_ACK) begin
            nxt_state.ack_n = 1'h0;
            nxt_state.ack_oe_n = 1'h0;
          end else begin
            nxt_state.flt_n = 1'h0;
            nxt_state.flt_oe_n = 1'h0;
            if (mem_resp == `HBCS_RSP_RTY && !state_ff.sync) begin
              nxt_state.tip_n = 1'h0;
              nxt_state.tip_oe_n = 1'h0;
            end
          end
        end else begin
          nxt_state.cnt = state_ff.cnt - 4'h1;
        end
      end
      hs_rsp: begin
        nxt_state.st = hs_idle;
        nxt_state.ack_n = 1'h1;
        nxt_state.ack_oe_n = 1'h1;
        nxt_state.flt_n = 1'h1;
        nxt_state.flt_oe_n = 1'h1;
        nxt_state.tip_n = 1'h1;
        nxt_state.tip_oe_n = 1'h1;
      end
      hs_slv: begin
        if (!bus.sync_cycle_ack_n || !bus.bus_fault_n) begin
          nxt_state.st = hs_idle;
          nxt_state.cpu_done = 1'h1;
          nxt_state.cpu_fault = ~bus.bus_fault_n;
          nxt_state.siz_oe_n = 1'h1;
          nxt_state.ack_n = 1'h1;
          nxt_state.ack_oe_n = 1'h1;
          nxt_state.tip_n = 1'h1;
          nxt_state.tip_oe_n = 1'h1;
        end else if (!bus.slave_cycle_done_n) begin
          nxt_state.ack_n = 1'h0;
          nxt_state.ack_oe_n = 1'h0;
        end
      end
      default: begin
        nxt_state.st = hs_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= '{st: hs_idle, cnt: 4'h0, sync: 1'h0, siz_o: 2'h0, siz_oe_n: 1'h1, sstb_n: 1'h1,
                    ack_n: 1'h1, ack_oe_n: 1'h1, flt_n: 1'h1, flt_oe_n: 1'h1, tip_n: 1'h1,
                    tip_oe_n: 1'h1, mem_cyc: 1'h0, mem_size: 2'h0, mem_space: 3'h0,
                    mem_snoop: 2'h0, cpu_done: 1'h0, cpu_fault: 1'h0, cpu_refused: 1'h0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bus.bus_sync = state_ff.sync;
  assign bus.host_size_o = state_ff.siz_o;
  assign bus.host_size_oe_n = state_ff.siz_oe_n;
  assign bus.host_ack_o = state_ff.ack_n;
  assign bus.host_ack_oe_n = state_ff.ack_oe_n;
  assign bus.host_fault_o = state_ff.flt_n;
  assign bus.host_fault_oe_n = state_ff.flt_oe_n;
  assign bus.host_tip_o = state_ff.tip_n;
  assign bus.host_tip_oe_n = state_ff.tip_oe_n;
  assign bus.slave_strobe_n = state_ff.sstb_n;
  assign mem_cyc = state_ff.mem_cyc;
  assign mem_size = state_ff.mem_size;
  assign mem_space = state_ff.mem_space;
  assign mem_snoop = state_ff.mem_snoop;
  assign cpu_done = state_ff.cpu_done;
  assign cpu_fault = state_ff.cpu_fault;
  assign cpu_refused = state_ff.cpu_refused;
endmodule

// ===== rtl/hbcs_if.sv
// shared host bus pins between device end and host end
`timescale 1ns/100ps
interface hbcs_if;
  logic       bus_sync;
  logic [1:0] dev_size_o;
  logic       dev_size_oe_n;
  logic [1:0] host_size_o;
  logic       host_size_oe_n;
  logic [1:0] transfer_size;
  logic       dev_ack_o;
  logic       dev_ack_oe_n;
  logic       host_ack_o;
  logic       host_ack_oe_n;
  logic       sync_cycle_ack_n;
  logic       dev_fault_o;
  logic       dev_fault_oe_n;
  logic       host_fault_o;
  logic       host_fault_oe_n;
  logic       bus_fault_n;
  logic       dev_tip_o;
  logic       dev_tip_oe_n;
  logic       host_tip_o;
  logic       host_tip_oe_n;
  logic       transfer_in_progress_n;
  logic       master_strobe_n;
  logic       slave_strobe_n;
  logic       slave_cycle_done_n;
  logic [2:0] space_qualifier;
  logic       space_qualifier_oe_n;
  logic [1:0] snoop_level;
  logic       snoop_level_oe_n;
  logic       master_n;
  logic       master_oe_n;
  logic       fetch_n;
  // wired levels: low-active pins pulled up, size reads 0 when undriven
  assign transfer_size = !dev_size_oe_n ? dev_size_o : (!host_size_oe_n ? host_size_o : 2'h0);
  assign sync_cycle_ack_n = (dev_ack_oe_n | dev_ack_o) & (host_ack_oe_n | host_ack_o);
  assign bus_fault_n = (dev_fault_oe_n | dev_fault_o) & (host_fault_oe_n | host_fault_o);
  assign transfer_in_progress_n = (dev_tip_oe_n | dev_tip_o) & (host_tip_oe_n | host_tip_o);
  modport dev (
    input  bus_sync, transfer_size, sync_cycle_ack_n, bus_fault_n, transfer_in_progress_n, slave_strobe_n,
    output dev_size_o, dev_size_oe_n, dev_ack_o, dev_ack_oe_n, dev_fault_o, dev_fault_oe_n,
    output dev_tip_o, dev_tip_oe_n, master_strobe_n, slave_cycle_done_n, space_qualifier,
    output space_qualifier_oe_n, snoop_level, snoop_level_oe_n, master_n, master_oe_n, fetch_n
  );
  modport host (
    input  transfer_size, sync_cycle_ack_n, bus_fault_n, transfer_in_progress_n, master_strobe_n,
    input  slave_cycle_done_n, space_qualifier, snoop_level, master_n, fetch_n,
    output bus_sync, host_size_o, host_size_oe_n, host_ack_o, host_ack_oe_n, host_fault_o,
    output host_fault_oe_n, host_tip_o, host_tip_oe_n, slave_strobe_n
  );
endinterface

// ===== rtl/hbcs_pkg.sv
// types for the host bus cycle signalling ends
package hbcs_pkg;
  typedef enum logic [1:0] {ds_idle, ds_mst, ds_slv, ds_wait} hbcs_dev_e;
  typedef enum logic [1:0] {hs_idle, hs_mem, hs_rsp, hs_slv} hbcs_host_e;
  typedef struct packed {
    hbcs_dev_e  st;
    logic [3:0] cnt;
    logic [1:0] siz;
    logic [2:0] sq;
    logic [1:0] sc;
    logic [1:0] s_siz;
    logic       siz_oe_n;
    logic       sq_oe_n;
    logic       sc_oe_n;
    logic       mst_n;
    logic       mst_oe_n;
    logic       mstb_n;
    logic       tip_n;
    logic       tip_oe_n;
    logic       ack_n;
    logic       ack_oe_n;
    logic       flt_n;
    logic       flt_oe_n;
    logic       done_n;
    logic       fetch_n;
    logic       m_done;
    logic       m_fault;
    logic       s_start;
    logic       s_end;
  } hbcs_dev_s;
  typedef struct packed {
    hbcs_host_e st;
    logic [3:0] cnt;
    logic       sync;
    logic [1:0] siz_o;
    logic       siz_oe_n;
    logic       sstb_n;
    logic       ack_n;
    logic       ack_oe_n;
    logic       flt_n;
    logic       flt_oe_n;
    logic       tip_n;
    logic       tip_oe_n;
    logic       mem_cyc;
    logic [1:0] mem_size;
    logic [2:0] mem_space;
    logic [1:0] mem_snoop;
    logic       cpu_done;
    logic       cpu_fault;
    logic       cpu_refused;
  } hbcs_host_s;
endpackage
